// ===== src/pport_pkg.sv
`default_nettype none
package pport_pkg;
  // ***************************************************************
  // register map (byte addresses, one aligned word each)
  // ***************************************************************
  localparam logic [11:0] CTRL_OFFSET     = 12'h000;
  localparam logic [11:0] MODE_OFFSET     = 12'h004;
  localparam logic [11:0] PIN_FUNC_OFFSET = 12'h008;

  // port_control fields
  localparam int BEP_BIT  = 2;
  localparam int WRITE_STROBE_POLARITY_BIT = 1;
  localparam int READ_STROBE_POLARITY_BIT = 0;
  localparam logic [2:0] CTRL_POL_RESET = 3'h0;

  // port_mode_config fields
  localparam int MODE_BUSY_BIT = 15;
  localparam int MODE_FIELD_LO = 8;
  localparam int MODE_FIELD_HI = 9;
  localparam logic [1:0] MODE_RESET   = 2'h0;
  localparam logic [1:0] MODE_MASTER1 = 2'h3;

  // pin function select: 1 = pin carries an address line
  localparam int SEL_BE_BIT = 0;
  localparam int SEL_WR_BIT = 1;
  localparam int SEL_RD_BIT = 2;
  localparam logic [2:0] PIN_SEL_RESET = 3'h0;

  // pin indices of the strobe outputs
  localparam int PIN_BE    = 0;
  localparam int PIN_WR    = 1;
  localparam int PIN_RD    = 2;
  localparam int PIN_EN    = 3;
  localparam int NUM_PINS  = 4;

  // outputs leave reset inactive for the active-low reset polarity
  localparam logic PIN_RESET = 1'h1;
endpackage
`default_nettype wire

// ===== src/strobe_pin_driver.sv
`default_nettype none
module strobe_pin_driver (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // pin control
  input  wire logic active,
  input  wire logic polarity,
  input  wire logic as_address,
  input  wire logic address_bit,
  // pin level
  output logic      pin_out
);
  logic next_pin_out;

  // address use overrides polarity; otherwise polarity picks the level
  always_comb begin
    if (as_address) begin
      next_pin_out = address_bit;
    end else begin
      next_pin_out = polarity ? active : ~active;
    end
  end

  // registered so the pin never glitches between decode terms
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= pport_pkg::PIN_RESET;
    end else begin
      pin_out <= next_pin_out;
    end
  end
endmodule
`default_nettype wire

// ===== src/parallel_port_strobe_config.sv
// Chosen here: the APB slave port and the register addresses.
`default_nettype none
module parallel_port_strobe_config (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // strobe requests from the port engine, active high
  input  wire logic        byte_enable_req,
  input  wire logic        write_req,
  input  wire logic        read_req,
  input  wire logic        cycle_enable_req,
  input  wire logic        cycle_is_read,
  // address bits for pins used as address lines
  input  wire logic [2:0]  addr_bits,
  // external strobe pins
  output logic             byte_enable_out,
  output logic             write_strobe_out,
  output logic             enable_strobe_out,
  output logic             read_strobe_out
);
  // ***************************************************************
  // register file
  // ***************************************************************
  logic [2:0] ctrl_pol;
  logic [1:0] port_mode_field;
  logic [2:0] pin_sel;
  logic [2:0] next_ctrl_pol;
  logic [1:0] next_port_mode_field;
  logic [2:0] next_pin_sel;

  logic byte_enable_polarity;
  logic write_strobe_polarity;
  logic read_strobe_polarity;
  logic master1;
  logic busy;
  logic access;
  logic hit_ctrl;
  logic hit_mode;
  logic hit_pin;

  assign byte_enable_polarity  = ctrl_pol[pport_pkg::BEP_BIT];
  assign write_strobe_polarity = ctrl_pol[pport_pkg::WRITE_STROBE_POLARITY_BIT];
  assign read_strobe_polarity  = ctrl_pol[pport_pkg::READ_STROBE_POLARITY_BIT];
  // only 11 selects master mode 1, all else uses split strobes
  assign master1 = (port_mode_field == pport_pkg::MODE_MASTER1);
  assign busy    = byte_enable_req | write_req | read_req | cycle_enable_req;

  // decode; zero wait states, so the access phase always completes
  assign access   = psel & penable;
  assign hit_ctrl = (paddr == pport_pkg::CTRL_OFFSET);
  assign hit_mode = (paddr == pport_pkg::MODE_OFFSET);
  assign hit_pin  = (paddr == pport_pkg::PIN_FUNC_OFFSET);
  assign pready   = 1'b1;
  assign pslverr  = access & ~(hit_ctrl | hit_mode | hit_pin);

  // write path; only the lanes that hold implemented bits matter.
  // settings take effect at once, even mid transfer: software keeps
  // them still while the port is busy
  always_comb begin
    next_ctrl_pol        = ctrl_pol;
    next_port_mode_field = port_mode_field;
    next_pin_sel         = pin_sel;
    if (access && pwrite) begin
      if (hit_ctrl && pstrb[0]) begin
        next_ctrl_pol = pwdata[2:0];
      end
      if (hit_mode && pstrb[1]) begin
        next_port_mode_field =
          pwdata[pport_pkg::MODE_FIELD_HI:pport_pkg::MODE_FIELD_LO];
      end
      if (hit_pin && pstrb[0]) begin
        next_pin_sel = pwdata[2:0];
      end
    end
  end

  // register storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_pol        <= pport_pkg::CTRL_POL_RESET;
      port_mode_field <= pport_pkg::MODE_RESET;
      pin_sel         <= pport_pkg::PIN_SEL_RESET;
    end else begin
      ctrl_pol        <= next_ctrl_pol;
      port_mode_field <= next_port_mode_field;
      pin_sel         <= next_pin_sel;
    end
  end

  logic [31:0] next_prdata;

  // read path; unimplemented bits read zero, busy is live state.
  // the word is taken at the end of setup so it stands through access
  always_comb begin
    next_prdata = prdata;
    if (psel && !penable) begin
      next_prdata = 32'h0000_0000;
      if (hit_ctrl) begin
        next_prdata[2:0] = ctrl_pol;
      end else if (hit_mode) begin
        next_prdata[pport_pkg::MODE_FIELD_HI:pport_pkg::MODE_FIELD_LO] =
          port_mode_field;
        next_prdata[pport_pkg::MODE_BUSY_BIT] = busy;
      end else if (hit_pin) begin
        next_prdata[2:0] = pin_sel;
      end
    end
  end

  // read data register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= next_prdata;
    end
  end

  // ***************************************************************
  // strobe pin mapping
  // ***************************************************************
  logic [pport_pkg::NUM_PINS-1:0] pin_active;
  logic [pport_pkg::NUM_PINS-1:0] pin_pol;
  logic [pport_pkg::NUM_PINS-1:0] pin_addr;
  logic [pport_pkg::NUM_PINS-1:0] pin_abit;
  logic [pport_pkg::NUM_PINS-1:0] pin_level;

  // master mode 1 moves the write pin to enable, read pin to r/w
  always_comb begin
    pin_active[pport_pkg::PIN_BE] = byte_enable_req;
    pin_active[pport_pkg::PIN_WR] = master1 ? 1'b0 : write_req;
    pin_active[pport_pkg::PIN_RD] = master1 ? cycle_is_read
                                            : read_req;
    pin_active[pport_pkg::PIN_EN] = master1 ? cycle_enable_req
                                            : 1'b0;
    pin_pol[pport_pkg::PIN_BE] = byte_enable_polarity;
    pin_pol[pport_pkg::PIN_WR] = write_strobe_polarity;
    pin_pol[pport_pkg::PIN_RD] = read_strobe_polarity;
    pin_pol[pport_pkg::PIN_EN] = write_strobe_polarity;
    // enable shares the write pin, so it shares its address select
    pin_addr[pport_pkg::PIN_BE] = pin_sel[pport_pkg::SEL_BE_BIT];
    pin_addr[pport_pkg::PIN_WR] = pin_sel[pport_pkg::SEL_WR_BIT];
    pin_addr[pport_pkg::PIN_RD] = pin_sel[pport_pkg::SEL_RD_BIT];
    pin_addr[pport_pkg::PIN_EN] = pin_sel[pport_pkg::SEL_WR_BIT];
    pin_abit[pport_pkg::PIN_BE] = addr_bits[pport_pkg::SEL_BE_BIT];
    pin_abit[pport_pkg::PIN_WR] = addr_bits[pport_pkg::SEL_WR_BIT];
    pin_abit[pport_pkg::PIN_RD] = addr_bits[pport_pkg::SEL_RD_BIT];
    pin_abit[pport_pkg::PIN_EN] = addr_bits[pport_pkg::SEL_WR_BIT];
  end

  // one registered driver per pin
  for (genvar i = 0; i < pport_pkg::NUM_PINS; i++) begin : g_pin
    strobe_pin_driver u_drv (
      .pclk        (pclk),
      .presetn     (presetn),
      .active      (pin_active[i]),
      .polarity    (pin_pol[i]),
      .as_address  (pin_addr[i]),
      .address_bit (pin_abit[i]),
      .pin_out     (pin_level[i])
    );
  end

  assign byte_enable_out   = pin_level[pport_pkg::PIN_BE];
  assign write_strobe_out  = pin_level[pport_pkg::PIN_WR];
  assign read_strobe_out   = pin_level[pport_pkg::PIN_RD];
  assign enable_strobe_out = pin_level[pport_pkg::PIN_EN];

  // ***************************************************************
  // assertions
  // ***************************************************************
  sequence s_ctrl_write;
    psel && penable && pwrite && hit_ctrl && pstrb[0];
  endsequence

  sequence s_be_request;
    !pin_sel[pport_pkg::SEL_BE_BIT] && byte_enable_req;
  endsequence

  // software writes while idle, so the idle level shows a new polarity
  sequence s_be_idle;
    !pin_sel[pport_pkg::SEL_BE_BIT] && !byte_enable_req;
  endsequence

  a_ctrl_write_lands: assert property (@(posedge pclk)
    disable iff (!presetn)
    s_ctrl_write ##1 s_be_idle |=>
      byte_enable_out == !$past(pwdata[pport_pkg::BEP_BIT], 2))
    else $error("byte enable idle level does not follow polarity");

  a_be_polarity: assert property (@(posedge pclk)
    disable iff (!presetn)
    s_be_request |=> byte_enable_out == $past(byte_enable_polarity))
    else $error("byte enable active level wrong");

  a_wr_strobe_level: assert property (@(posedge pclk)
    disable iff (!presetn)
    !master1 && !pin_sel[pport_pkg::SEL_WR_BIT] |=>
      write_strobe_out == ($past(write_strobe_polarity) ==
                           $past(write_req)))
    else $error("write strobe level wrong in split strobe mode");

  a_en_strobe_level: assert property (@(posedge pclk)
    disable iff (!presetn)
    master1 && !pin_sel[pport_pkg::SEL_WR_BIT] |=>
      enable_strobe_out == ($past(write_strobe_polarity) ==
                            $past(cycle_enable_req)) &&
      write_strobe_out == !$past(write_strobe_polarity))
    else $error("enable strobe level wrong in master mode 1");

  a_rd_strobe_level: assert property (@(posedge pclk)
    disable iff (!presetn)
    !master1 && !pin_sel[pport_pkg::SEL_RD_BIT] && read_req |=>
      read_strobe_out == $past(read_strobe_polarity))
    else $error("read strobe active level wrong");

  a_rw_strobe_level: assert property (@(posedge pclk)
    disable iff (!presetn)
    master1 && !pin_sel[pport_pkg::SEL_RD_BIT] |=>
      read_strobe_out == ($past(read_strobe_polarity) ==
                          $past(cycle_is_read)))
    else $error("read/write strobe level wrong in master mode 1");

  a_mode_split_idle: assert property (@(posedge pclk)
    disable iff (!presetn)
    (port_mode_field != 2'h3) && !pin_sel[pport_pkg::SEL_WR_BIT] |=>
      enable_strobe_out == !$past(write_strobe_polarity))
    else $error("enable strobe active outside master mode 1");

  a_addr_overrides: assert property (@(posedge pclk)
    disable iff (!presetn)
    pin_sel[pport_pkg::SEL_RD_BIT] |=>
      read_strobe_out == $past(addr_bits[pport_pkg::SEL_RD_BIT]))
    else $error("address pin does not carry its address bit");
endmodule
`default_nettype wire

// ===== verif/strobe_sink.sv
`default_nettype none
// ****************************************
// external peripheral latching the strobes
// ****************************************
module strobe_sink (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // strobe pins
  input  wire logic       be_pin,
  input  wire logic       wr_pin,
  input  wire logic       rd_pin,
  input  wire logic       en_pin,
  // captured levels {en, rd, wr, be}
  output logic      [3:0] seen
);
  timeunit 1ns;
  timeprecision 1ps;

  // latches pins on its own edge, one cycle late, like a real device
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) seen <= 4'hf;
    else seen <= {en_pin, rd_pin, wr_pin, be_pin};
  end
endmodule
`default_nettype wire

// ===== verif/parallel_port_strobe_config_tb.sv
`default_nettype none
`define check_eq(got, exp) begin num_checks++; if ((got) !== (exp)) begin \
  errors++; $display("BAD %0t got %h expected %h", $time, got, exp); end end
module parallel_port_strobe_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct { logic [3:0] pins; int due; } pin_note_t;
  typedef struct { logic [31:0] data; logic err; logic rd; } bus_note_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic [3:0]  pstrb, seen;
  logic        be_req, wr_req, rd_req, en_req, is_rd;
  logic [2:0]  addr_bits, pol, sel;
  logic [1:0]  mode;
  logic        be_o, wr_o, en_o, rd_o;
  int          errors, num_checks, cyc, cycles, seed;
  pin_note_t   pq[$];
  bus_note_t   bq[$];

  parallel_port_strobe_config i_parallel_port_strobe_config (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .byte_enable_req(be_req), .write_req(wr_req), .read_req(rd_req),
    .cycle_enable_req(en_req), .cycle_is_read(is_rd),
    .addr_bits(addr_bits), .byte_enable_out(be_o), .write_strobe_out(wr_o),
    .enable_strobe_out(en_o), .read_strobe_out(rd_o));
  strobe_sink i_strobe_sink (
    .pclk(pclk), .presetn(presetn), .be_pin(be_o), .wr_pin(wr_o),
    .rd_pin(rd_o), .en_pin(en_o), .seen(seen));

  // ****************************************
  // model, drivers and watchers
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic complete_run();
    if (errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // expected pins {en, rd, wr, be} from the bench's own register copy
  function automatic logic [3:0] exp_pins(input logic [4:0] r,
                                          input logic [2:0] ab);
    logic m1;
    m1 = (mode == pport_pkg::MODE_MASTER1);
    return {sel[1] ? ab[1] : ~((r[1] & m1) ^ pol[1]),
            sel[2] ? ab[2] : ~((m1 ? r[0] : r[2]) ^ pol[0]),
            sel[1] ? ab[1] : ~((r[3] & ~m1) ^ pol[1]),
            sel[0] ? ab[0] : ~(r[4] ^ pol[2])};
  endfunction

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] dat, input logic [3:0] s,
                     input logic [31:0] x, input logic e);
    bq.push_back('{x, e, !w});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dat;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // random requests; the last cycle is idle so settings change only idle
  task automatic drive(input int n);
    logic [4:0] r;
    logic [2:0] ab;
    for (int j = 0; j < n; j++) begin
      r = (j == n - 1) ? 5'h0 : 5'($random(seed));
      ab = 3'($random(seed));
      {be_req, wr_req, rd_req, en_req, is_rd} <= r;
      addr_bits <= ab;
      pq.push_back('{exp_pins(r, ab), cyc + 2});
      @(posedge pclk);
    end
  endtask

  // due two edges on: design register, then the sink's latch
  always @(negedge pclk) begin
    while (pq.size() > 0 && pq[0].due == cyc) begin
      `check_eq(seen, pq[0].pins)
      void'(pq.pop_front());
    end
    cyc++;
  end

  // bus answers taken at the access edge; also the hang limit
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      if (bq[0].rd) `check_eq(prdata, bq[0].data)
      `check_eq(pslverr, bq[0].err)
      void'(bq.pop_front());
    end
    cycles++;
    if (cycles == 5000) begin
      errors++;
      complete_run();
    end
  end

  initial begin
    seed = 32'hdb9f;
    {errors, num_checks, cyc, cycles} = '0;
    {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {be_req, wr_req, rd_req, en_req, is_rd, addr_bits} = '0;
    {pol, mode, sel} = '0;
    repeat (3) @(posedge pclk);
    `check_eq({en_o, rd_o, wr_o, be_o}, 4'hf)
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, pport_pkg::CTRL_OFFSET, 32'h0, 4'hf, 32'h0, 1'b0);
    apb(1'b0, pport_pkg::MODE_OFFSET, 32'h0, 4'hf, 32'h0, 1'b0);
    apb(1'b0, pport_pkg::PIN_FUNC_OFFSET, 32'h0, 4'hf, 32'h0, 1'b0);
    for (int i = 0; i < 32; i++) begin
      pol = i[2:0];
      mode = i[4:3];
      sel = (i % 3 == 0) ? 3'h0 : 3'($random(seed));
      d = $random(seed);
      apb(1'b1, pport_pkg::CTRL_OFFSET, {d[31:3], pol}, 4'hf, 32'h0, 1'b0);
      apb(1'b1, pport_pkg::MODE_OFFSET, {d[31:10], mode, d[7:0]}, 4'hf,
          32'h0, 1'b0);
      apb(1'b1, pport_pkg::PIN_FUNC_OFFSET, {d[31:3], sel}, 4'h1, 32'h0, 1'b0);
      apb(1'b0, pport_pkg::CTRL_OFFSET, 32'h0, 4'hf, {29'h0, pol}, 1'b0);
      apb(1'b0, pport_pkg::MODE_OFFSET, 32'h0, 4'hf, {22'h0, mode, 8'h0},
          1'b0);
      apb(1'b0, pport_pkg::PIN_FUNC_OFFSET, 32'h0, 4'hf, {29'h0, sel}, 1'b0);
      drive(10);
    end
    // unmapped place and writes on the wrong byte lane are refused
    apb(1'b1, 12'h00c, d, 4'hf, 32'h0, 1'b1);
    apb(1'b0, 12'h00c, 32'h0, 4'hf, 32'h0, 1'b1);
    apb(1'b1, pport_pkg::CTRL_OFFSET, 32'h0, 4'he, 32'h0, 1'b0);
    apb(1'b1, pport_pkg::MODE_OFFSET, 32'h0, 4'hd, 32'h0, 1'b0);
    apb(1'b0, pport_pkg::CTRL_OFFSET, 32'h0, 4'hf, {29'h0, pol}, 1'b0);
    apb(1'b0, pport_pkg::MODE_OFFSET, 32'h0, 4'hf, {22'h0, mode, 8'h0}, 1'b0);
    // busy follows a live request
    wr_req <= 1'b1;
    @(posedge pclk);
    apb(1'b0, pport_pkg::MODE_OFFSET, 32'h0, 4'hf,
        {16'h0, 1'b1, 5'h0, mode, 8'h0}, 1'b0);
    wr_req <= 1'b0;
    repeat (4) @(posedge pclk);
    complete_run();
  end
endmodule
`default_nettype wire
